// ===== rtl/scf_cmd_decoder.sv
// Purpose: instruction front end of a serial flash, link side on i_sck
// Assumes: input sampled on rising i_sck, output driven on falling i_sck
// Notes: i_rd_data answers o_rd_addr combinationally in the link domain
// Function
// - opcode takes two clocks in quad protocol, eight in single-bit.
// - address, dummy and data bytes take two clocks quad, eight single; quad read/program data and quad io read phases take two.
// - dual output read data and dual io read phases take four clocks.
// - quad read and quad program need the quad io config bit set.
// - reset fires only straight after reset arm; other legal opcodes disarm.
// - idle opcode disarms a pending reset and is passed to the core as a command.
// - soft reset gives single-bit, burst eight, status defaults except bits 4,5.
// - soft reset clears the quad io config bit.
// - soft reset during program or erase aborts it.
// - basic read works in single-bit protocol only.
// - basic read streams bytes from address, incrementing, until frame end.
// - read pointer wraps from top address to zero.
// - quad enter makes later instructions four bits wide until quad exit or soft reset.
// - quad exit is accepted as eight-clock or two-clock opcode.
// - erase address keeps bits down to 12, 16, 15 or 13.
// - suspend and resume carry no further cycles, in both protocols.
// - protection map read has quad dummy only; write takes data bytes.
// - freeze, unprotect and lockdown write opcodes have no address.
// - secure id read and program take two address bytes.
// - deep sleep has no cycles; wake streams id after three address bytes.
// - power-up is single-bit protocol.
// - quad exit returns to single-bit protocol.
module scf_cmd_decoder #(
	parameter int ADDR_W = scf_pkg::ADDR_BITS,
	parameter int PMAP_N = scf_pkg::PMAP_BYTES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sck,
	input wire logic i_cs_n,
	input wire logic [3:0] i_sio,
	output logic [3:0] o_sio,
	output logic [3:0] o_sio_oe_n,
	output logic [23:0] o_rd_addr,
	output logic o_rd_sid,
	input wire logic [7:0] i_rd_data,
	input wire logic [8*PMAP_N-1:0] i_prot_map,
	input wire logic [7:0] i_dev_id,
	output logic o_quad_mode,
	output logic o_cmd_valid,
	output logic [7:0] o_cmd_op,
	output logic [23:0] o_cmd_addr,
	output logic o_wr_valid,
	output logic [7:0] o_wr_byte,
	output logic o_suspend,
	output logic o_resume,
	output logic o_abort,
	output logic o_deep_sleep,
	input wire logic i_busy,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_status,
	input wire logic [7:0] i_cfg,
	input wire logic [1:0] i_burst,
	output logic [7:0] o_status,
	output logic [7:0] o_cfg,
	output logic [1:0] o_burst_len
);
	localparam logic [23:0] AMASK = 24'((25'h1 << ADDR_W) - 25'h1);
	localparam logic [2:0] PM_LAST = 3'(PMAP_N - 1);

	// ==========================================================
	// functions
	function automatic scf_pkg::scf_cmd_t decode(input logic [7:0] op, input logic quad,
			input logic qcf);
		scf_pkg::scf_cmd_t c;
		c = '{legal: 1'h1, n_addr: 2'h0, n_dummy: 2'h0, dir: scf_pkg::DIR_NONE,
			src: scf_pkg::SRC_ARRAY};
		case (op)
			scf_pkg::OP_IDLE, scf_pkg::OP_RST_ARM, scf_pkg::OP_RST_FIRE,
			scf_pkg::OP_QUAD_EXIT, scf_pkg::OP_SUSPEND, scf_pkg::OP_RESUME,
			scf_pkg::OP_FREEZE_PMAP, scf_pkg::OP_UNPROTECT, scf_pkg::OP_LOCK_SID,
			scf_pkg::OP_DEEP_SLEEP: c.legal = 1'h1;
			scf_pkg::OP_QUAD_ENTER: c.legal = !quad;
			scf_pkg::OP_READ: begin
				c.legal = !quad;
				c.n_addr = 2'h3;
				c.dir = scf_pkg::DIR_OUT;
			end
			scf_pkg::OP_DUAL_OUT_RD, scf_pkg::OP_DUAL_IO_RD, scf_pkg::OP_QUAD_OUT_RD: begin
				c.legal = !quad && (qcf || op != scf_pkg::OP_QUAD_OUT_RD);
				c.n_addr = 2'h3;
				c.n_dummy = 2'h1;
				c.dir = scf_pkg::DIR_OUT;
			end
			scf_pkg::OP_QUAD_IO_RD: begin
				c.legal = !quad && qcf;
				c.n_addr = 2'h3;
				c.n_dummy = 2'h3;
				c.dir = scf_pkg::DIR_OUT;
			end
			scf_pkg::OP_QUAD_PP, scf_pkg::OP_PP: begin
				c.legal = (op == scf_pkg::OP_PP) || (!quad && qcf);
				c.n_addr = 2'h3;
				c.dir = scf_pkg::DIR_IN;
			end
			scf_pkg::OP_SECTOR_ER, scf_pkg::OP_BLOCK_ER: c.n_addr = 2'h3;
			scf_pkg::OP_RD_PMAP: begin
				c.n_dummy = quad ? 2'h1 : 2'h0;
				c.dir = scf_pkg::DIR_OUT;
				c.src = scf_pkg::SRC_PMAP;
			end
			scf_pkg::OP_WR_PMAP, scf_pkg::OP_NV_LOCK: c.dir = scf_pkg::DIR_IN;
			scf_pkg::OP_RD_SID: begin
				c.n_addr = 2'h2;
				c.n_dummy = quad ? 2'h3 : 2'h1;
				c.dir = scf_pkg::DIR_OUT;
				c.src = scf_pkg::SRC_SID;
			end
			scf_pkg::OP_PRG_SID: begin
				c.n_addr = 2'h2;
				c.dir = scf_pkg::DIR_IN;
			end
			scf_pkg::OP_WAKE_ID: begin
				c.n_addr = 2'h3;
				c.dir = scf_pkg::DIR_OUT;
				c.src = scf_pkg::SRC_ID;
			end
			default: c.legal = 1'h0;
		endcase
		return c;
	endfunction : decode

	// bits moved per clock in the current phase
	function automatic logic [2:0] bus_w(input scf_pkg::scf_state_t st, input logic [7:0] op,
			input logic quad);
		logic data;
		data = (st == scf_pkg::ST_DATA);
		if (quad) begin
			bus_w = 3'h4;
		end else if (st == scf_pkg::ST_OPC) begin
			bus_w = 3'h1;
		end else begin
			case (op)
				scf_pkg::OP_QUAD_OUT_RD, scf_pkg::OP_QUAD_PP: bus_w = data ? 3'h4 : 3'h1;
				scf_pkg::OP_QUAD_IO_RD: bus_w = 3'h4;
				scf_pkg::OP_DUAL_OUT_RD: bus_w = data ? 3'h2 : 3'h1;
				scf_pkg::OP_DUAL_IO_RD: bus_w = 3'h2;
				default: bus_w = 3'h1;
			endcase
		end
	endfunction : bus_w

	function automatic logic [2:0] last_cnt(input logic [2:0] w);
		case (w)
			3'h4: last_cnt = 3'h1;
			3'h2: last_cnt = 3'h3;
			default: last_cnt = 3'h7;
		endcase
	endfunction : last_cnt

	function automatic logic [7:0] shin(input logic [7:0] sh, input logic [3:0] sio,
			input logic [2:0] w);
		case (w)
			3'h4: shin = {sh[3:0], sio};
			3'h2: shin = {sh[5:0], sio[1:0]};
			default: shin = {sh[6:0], sio[0]};
		endcase
	endfunction : shin

	function automatic logic [23:0] er_addr(input logic [7:0] op, input logic [23:0] a);
		logic [4:0] lsb;
		logic bot;
		logic top;
		bot = ~|a[ADDR_W-1:16];
		top = &a[ADDR_W-1:16];
		if (op == scf_pkg::OP_SECTOR_ER) lsb = scf_pkg::SECTOR_LSB;
		else if (bot) lsb = a[15] ? scf_pkg::BLK32_LSB : scf_pkg::BLK8_LSB;
		else if (top) lsb = a[15] ? scf_pkg::BLK8_LSB : scf_pkg::BLK32_LSB;
		else lsb = scf_pkg::BLK64_LSB;
		if (op == scf_pkg::OP_SECTOR_ER || op == scf_pkg::OP_BLOCK_ER) begin
			er_addr = a & ~((24'h1 << lsb) - 24'h1);
		end else begin
			er_addr = a;
		end
	endfunction : er_addr

	// ==========================================================
	// link domain: frame decode
	logic frame_rst;
	scf_pkg::scf_state_t state_r, state_nxt;
	scf_pkg::scf_cmd_t cmd_r, cmd_nxt, dec;
	logic [7:0] op_r, op_nxt, sh_r, sh_nxt;
	logic [2:0] cnt_r, w, pm_idx_r;
	logic [1:0] bcnt_r;
	logic [23:0] addr_r, addr_nxt;
	logic byte_end, hdr_done, fwd, rd_sid_r;
	logic quad_r, armed_r, qcf_s1_r, qcf_s2_r;
	logic [8*PMAP_N-1:0] pm_s1_r, pm_s2_r;
	logic [7:0] id_s1_r, id_s2_r;
	logic cmd_tgl_r, wr_tgl_r;
	logic [7:0] cmd_op_hold_r, wr_hold_r, cfg_r;
	logic [23:0] cmd_addr_hold_r;

	// chip select high ends the frame at once
	assign frame_rst = i_cs_n | ~i_rst_n;

	always_comb begin
		w = bus_w(state_r, op_r, quad_r);
		sh_nxt = shin(sh_r, i_sio, w);
		byte_end = (cnt_r == last_cnt(w));
		dec = decode(sh_nxt, quad_r, qcf_s2_r);
		cmd_nxt = (state_r == scf_pkg::ST_OPC) ? dec : cmd_r;
		op_nxt = (state_r == scf_pkg::ST_OPC) ? sh_nxt : op_r;
		addr_nxt = {addr_r[15:0], sh_nxt} & AMASK;
		fwd = !(op_nxt == scf_pkg::OP_RST_FIRE && !armed_r);
		hdr_done = 1'h0;
		state_nxt = state_r;
		if (byte_end) begin
			case (state_r)
				scf_pkg::ST_OPC: begin
					if (!dec.legal) begin
						state_nxt = scf_pkg::ST_HOLD;
					end else if (dec.n_addr != 2'h0) begin
						state_nxt = scf_pkg::ST_ADDR;
					end else begin
						hdr_done = 1'h1;
					end
				end
				scf_pkg::ST_ADDR: hdr_done = (bcnt_r == cmd_r.n_addr - 2'h1);
				scf_pkg::ST_DUMMY: begin
					if (bcnt_r == cmd_r.n_dummy - 2'h1) state_nxt = scf_pkg::ST_DATA;
				end
				default: state_nxt = state_r;
			endcase
		end
		if (hdr_done) begin
			if (cmd_nxt.n_dummy != 2'h0) state_nxt = scf_pkg::ST_DUMMY;
			else if (cmd_nxt.dir == scf_pkg::DIR_NONE) state_nxt = scf_pkg::ST_HOLD;
			else state_nxt = scf_pkg::ST_DATA;
		end
	end

	always_ff @(posedge i_sck or posedge frame_rst) begin
		if (frame_rst) begin
			state_r <= scf_pkg::ST_OPC;
			cmd_r <= '{legal: 1'h0, n_addr: 2'h0, n_dummy: 2'h0, dir: scf_pkg::DIR_NONE,
				src: scf_pkg::SRC_ARRAY};
			op_r <= 8'h00;
			sh_r <= 8'h00;
			cnt_r <= 3'h0;
			bcnt_r <= 2'h0;
		end else begin
			state_r <= state_nxt;
			cmd_r <= cmd_nxt;
			op_r <= op_nxt;
			sh_r <= sh_nxt;
			cnt_r <= byte_end ? 3'h0 : cnt_r + 3'h1;
			if (state_nxt != state_r) bcnt_r <= 2'h0;
			else if (byte_end) bcnt_r <= bcnt_r + 2'h1;
		end
	end

	// read pointer and data source index
	always_ff @(posedge i_sck or posedge frame_rst) begin
		if (frame_rst) begin
			addr_r <= 24'h000000;
			pm_idx_r <= 3'h0;
			rd_sid_r <= 1'h0;
		end else begin
			rd_sid_r <= (cmd_nxt.src == scf_pkg::SRC_SID);
			if (state_r == scf_pkg::ST_ADDR && byte_end) begin
				addr_r <= addr_nxt;
			end else if (state_r == scf_pkg::ST_DATA && byte_end
					&& cmd_r.dir == scf_pkg::DIR_OUT) begin
				addr_r <= (addr_r + 24'h1) & AMASK;
				if (pm_idx_r != PM_LAST) pm_idx_r <= pm_idx_r + 3'h1;
			end
		end
	end

	// persistent protocol state, survives frames
	always_ff @(posedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			quad_r <= 1'h0;
			armed_r <= 1'h0;
		end else if (state_r == scf_pkg::ST_OPC && byte_end && dec.legal) begin
			armed_r <= (sh_nxt == scf_pkg::OP_RST_ARM);
			if (sh_nxt == scf_pkg::OP_QUAD_ENTER) quad_r <= 1'h1;
			else if (sh_nxt == scf_pkg::OP_QUAD_EXIT) quad_r <= 1'h0;
			else if (sh_nxt == scf_pkg::OP_RST_FIRE && armed_r) quad_r <= 1'h0;
		end
	end

	// slow inputs from the core side
	always_ff @(posedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			qcf_s1_r <= 1'h0;
			qcf_s2_r <= 1'h0;
			pm_s1_r <= '0;
			pm_s2_r <= '0;
			id_s1_r <= 8'h00;
			id_s2_r <= 8'h00;
		end else begin
			qcf_s1_r <= cfg_r[scf_pkg::CFG_QUAD_IO_BIT];
			qcf_s2_r <= qcf_s1_r;
			pm_s1_r <= i_prot_map;
			pm_s2_r <= pm_s1_r;
			id_s1_r <= i_dev_id;
			id_s2_r <= id_s1_r;
		end
	end

	// toggles toward the core with data held stable
	always_ff @(posedge i_sck or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_tgl_r <= 1'h0;
			cmd_op_hold_r <= 8'h00;
			cmd_addr_hold_r <= 24'h000000;
			wr_tgl_r <= 1'h0;
			wr_hold_r <= 8'h00;
		end else begin
			if (hdr_done && fwd) begin
				cmd_tgl_r <= ~cmd_tgl_r;
				cmd_op_hold_r <= op_nxt;
				cmd_addr_hold_r <= (state_r == scf_pkg::ST_ADDR) ? addr_nxt : 24'h000000;
			end
			if (state_r == scf_pkg::ST_DATA && byte_end && cmd_r.dir == scf_pkg::DIR_IN) begin
				wr_tgl_r <= ~wr_tgl_r;
				wr_hold_r <= sh_nxt;
			end
		end
	end

	// ==========================================================
	// link domain: output on the falling edge
	logic [7:0] oshift_r, out_byte, src_byte;
	logic [3:0] sio_r, oe_n_r;

	always_comb begin
		case (cmd_r.src)
			scf_pkg::SRC_PMAP: src_byte = pm_s2_r[8*pm_idx_r +: 8];
			scf_pkg::SRC_ID: src_byte = id_s2_r;
			default: src_byte = i_rd_data;
		endcase
		out_byte = (cnt_r == 3'h0) ? src_byte : oshift_r;
	end

	always_ff @(negedge i_sck or posedge frame_rst) begin
		if (frame_rst) begin
			oshift_r <= 8'h00;
			sio_r <= 4'h0;
			oe_n_r <= 4'hf;
		end else if (state_r == scf_pkg::ST_DATA && cmd_r.dir == scf_pkg::DIR_OUT) begin
			case (w)
				3'h4: begin
					sio_r <= out_byte[7:4];
					oshift_r <= {out_byte[3:0], 4'h0};
					oe_n_r <= 4'h0;
				end
				3'h2: begin
					sio_r <= {2'h0, out_byte[7:6]};
					oshift_r <= {out_byte[5:0], 2'h0};
					oe_n_r <= 4'hc;
				end
				default: begin
					sio_r <= {2'h0, out_byte[7], 1'h0};
					oshift_r <= {out_byte[6:0], 1'h0};
					oe_n_r <= 4'hd;
				end
			endcase
		end else begin
			sio_r <= 4'h0;
			oe_n_r <= 4'hf;
		end
	end

	// ==========================================================
	// core domain
	logic [2:0] cmd_sync_r, wr_sync_r;
	logic cmd_evt, wr_evt;
	logic cmd_valid_r, wr_valid_r, suspend_r, resume_r, abort_r, sleep_r;
	logic [7:0] cmd_op_r, wr_byte_r, status_r;
	logic [23:0] cmd_addr_r;
	logic [1:0] burst_r;

	assign cmd_evt = cmd_sync_r[1] ^ cmd_sync_r[2];
	assign wr_evt = wr_sync_r[1] ^ wr_sync_r[2];

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_sync_r <= 3'h0;
			wr_sync_r <= 3'h0;
		end else begin
			cmd_sync_r <= {cmd_sync_r[1:0], cmd_tgl_r};
			wr_sync_r <= {wr_sync_r[1:0], wr_tgl_r};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_valid_r <= 1'h0;
			cmd_op_r <= 8'h00;
			cmd_addr_r <= 24'h000000;
			wr_valid_r <= 1'h0;
			wr_byte_r <= 8'h00;
		end else begin
			cmd_valid_r <= cmd_evt;
			wr_valid_r <= wr_evt;
			if (cmd_evt) begin
				cmd_op_r <= cmd_op_hold_r;
				cmd_addr_r <= er_addr(cmd_op_hold_r, cmd_addr_hold_r);
			end
			if (wr_evt) wr_byte_r <= wr_hold_r;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			suspend_r <= 1'h0;
			resume_r <= 1'h0;
			abort_r <= 1'h0;
			sleep_r <= 1'h0;
		end else begin
			suspend_r <= cmd_evt && cmd_op_hold_r == scf_pkg::OP_SUSPEND;
			resume_r <= cmd_evt && cmd_op_hold_r == scf_pkg::OP_RESUME;
			abort_r <= cmd_evt && cmd_op_hold_r == scf_pkg::OP_RST_FIRE && i_busy;
			if (cmd_evt && cmd_op_hold_r == scf_pkg::OP_DEEP_SLEEP) sleep_r <= 1'h1;
			else if (cmd_evt && cmd_op_hold_r == scf_pkg::OP_WAKE_ID) sleep_r <= 1'h0;
		end
	end

	// soft reset beats a register load in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			status_r <= scf_pkg::STATUS_RST;
			cfg_r <= scf_pkg::CFG_RST;
			burst_r <= scf_pkg::BURST_RST;
		end else if (cmd_evt && cmd_op_hold_r == scf_pkg::OP_RST_FIRE) begin
			status_r <= (status_r & scf_pkg::STATUS_KEEP)
				| (scf_pkg::STATUS_RST & ~scf_pkg::STATUS_KEEP);
			cfg_r[scf_pkg::CFG_QUAD_IO_BIT] <= scf_pkg::CFG_RST[scf_pkg::CFG_QUAD_IO_BIT];
			burst_r <= scf_pkg::BURST_RST;
		end else if (i_reg_wr) begin
			status_r <= i_status;
			cfg_r <= i_cfg;
			burst_r <= i_burst;
		end
	end

	// ==========================================================
	// outputs
	assign o_sio = sio_r;
	assign o_sio_oe_n = oe_n_r;
	assign o_rd_addr = addr_r;
	assign o_rd_sid = rd_sid_r;
	assign o_quad_mode = quad_r;
	assign o_cmd_valid = cmd_valid_r;
	assign o_cmd_op = cmd_op_r;
	assign o_cmd_addr = cmd_addr_r;
	assign o_wr_valid = wr_valid_r;
	assign o_wr_byte = wr_byte_r;
	assign o_suspend = suspend_r;
	assign o_resume = resume_r;
	assign o_abort = abort_r;
	assign o_deep_sleep = sleep_r;
	assign o_status = status_r;
	assign o_cfg = cfg_r;
	assign o_burst_len = burst_r;
endmodule : scf_cmd_decoder

// ===== rtl/scf_pkg.sv
// Purpose: shared constants and types of the serial flash command decoder
// Assumes: opcodes are eight bits, addresses are at most 24 bits
// Notes: status, configuration and burst defaults are plain values
package scf_pkg;
	// ==========================================================
	// opcodes
	localparam logic [7:0] OP_IDLE = 8'h00;
	localparam logic [7:0] OP_RST_ARM = 8'h66;
	localparam logic [7:0] OP_RST_FIRE = 8'h99;
	localparam logic [7:0] OP_QUAD_ENTER = 8'h38;
	localparam logic [7:0] OP_QUAD_EXIT = 8'hff;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_DUAL_OUT_RD = 8'h3b;
	localparam logic [7:0] OP_DUAL_IO_RD = 8'hbb;
	localparam logic [7:0] OP_QUAD_OUT_RD = 8'h6b;
	localparam logic [7:0] OP_QUAD_IO_RD = 8'heb;
	localparam logic [7:0] OP_QUAD_PP = 8'h32;
	localparam logic [7:0] OP_PP = 8'h02;
	localparam logic [7:0] OP_SECTOR_ER = 8'h20;
	localparam logic [7:0] OP_BLOCK_ER = 8'hd8;
	localparam logic [7:0] OP_SUSPEND = 8'hb0;
	localparam logic [7:0] OP_RESUME = 8'h30;
	localparam logic [7:0] OP_RD_PMAP = 8'h72;
	localparam logic [7:0] OP_WR_PMAP = 8'h42;
	localparam logic [7:0] OP_FREEZE_PMAP = 8'h8d;
	localparam logic [7:0] OP_NV_LOCK = 8'he8;
	localparam logic [7:0] OP_UNPROTECT = 8'h98;
	localparam logic [7:0] OP_RD_SID = 8'h88;
	localparam logic [7:0] OP_PRG_SID = 8'ha5;
	localparam logic [7:0] OP_LOCK_SID = 8'h85;
	localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_WAKE_ID = 8'hab;
	// ==========================================================
	// register defaults and fields
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] STATUS_KEEP = 8'h30;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam int CFG_QUAD_IO_BIT = 1;
	localparam logic [1:0] BURST_RST = 2'h0;
	localparam int PMAP_BYTES = 6;
	localparam int ADDR_BITS = 21;
	// ==========================================================
	// erase granularity, lowest kept address bit
	localparam logic [4:0] SECTOR_LSB = 5'h0c;
	localparam logic [4:0] BLK64_LSB = 5'h10;
	localparam logic [4:0] BLK32_LSB = 5'h0f;
	localparam logic [4:0] BLK8_LSB = 5'h0d;
	// ==========================================================
	// types
	typedef enum logic [1:0] {DIR_NONE = 2'h0, DIR_IN = 2'h1, DIR_OUT = 2'h2} scf_dir_t;
	typedef enum logic [1:0] {SRC_ARRAY = 2'h0, SRC_PMAP = 2'h1, SRC_SID = 2'h2,
		SRC_ID = 2'h3} scf_src_t;
	typedef struct packed {
		logic legal;
		logic [1:0] n_addr;
		logic [1:0] n_dummy;
		scf_dir_t dir;
		scf_src_t src;
	} scf_cmd_t;
	typedef enum logic [4:0] {ST_OPC = 5'h01, ST_ADDR = 5'h02, ST_DUMMY = 5'h04,
		ST_DATA = 5'h08, ST_HOLD = 5'h10} scf_state_t;
endpackage : scf_pkg

// ===== dv/scf_chk.sv
// Purpose: concurrent checks on the core-side ports and serial output enables of the command decoder
// Assumes: core events are one i_clk pulse wide
// Notes: attached by bind below
module scf_chk (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_cs_n,
	input wire logic i_busy,
	input wire logic [3:0] o_sio_oe_n,
	input wire logic o_quad_mode,
	input wire logic o_cmd_valid,
	input wire logic [7:0] o_cmd_op,
	input wire logic [23:0] o_cmd_addr,
	input wire logic o_suspend,
	input wire logic o_resume,
	input wire logic o_abort,
	input wire logic o_deep_sleep,
	input wire logic [7:0] o_status,
	input wire logic [7:0] o_cfg,
	input wire logic [1:0] o_burst_len
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ======
	// soft reset, abort, protocol
	fire_clears_a: assert property (
		o_cmd_valid && o_cmd_op == scf_pkg::OP_RST_FIRE |-> !o_quad_mode
		&& o_burst_len == 2'h0 && !o_cfg[scf_pkg::CFG_QUAD_IO_BIT]) else $error("reset left state");
	status_keep_a: assert property (
		o_cmd_valid && o_cmd_op == scf_pkg::OP_RST_FIRE |-> o_status == ($past(o_status) & 8'h30))
		else $error("status after reset wrong");
	abort_cause_a: assert property (
		o_abort |-> o_cmd_valid && o_cmd_op == scf_pkg::OP_RST_FIRE) else $error("stray abort");
	abort_need_a: assert property (
		o_cmd_valid && o_cmd_op == scf_pkg::OP_RST_FIRE && i_busy && $past(i_busy) |-> o_abort)
		else $error("abort missing");
	suspend_pulse_a: assert property (
		o_suspend |-> o_cmd_valid && o_cmd_op == scf_pkg::OP_SUSPEND ##1 !o_suspend)
		else $error("suspend pulse wrong");
	resume_pulse_a: assert property (
		o_resume |-> o_cmd_valid && o_cmd_op == scf_pkg::OP_RESUME ##1 !o_resume)
		else $error("resume pulse wrong");
	quad_enter_a: assert property (
		o_cmd_valid && o_cmd_op == scf_pkg::OP_QUAD_ENTER |-> o_quad_mode) else $error("no quad");
	quad_exit_a: assert property (
		o_cmd_valid && o_cmd_op == scf_pkg::OP_QUAD_EXIT |-> !o_quad_mode) else $error("still quad");
	quad_drive_a: assert property (
		o_quad_mode && o_sio_oe_n != 4'hf |-> o_sio_oe_n == 4'h0) else $error("quad drive width");
	idle_quiet_a: assert property (
		i_cs_n |-> o_sio_oe_n == 4'hf) else $error("driving while deselected");
	sector_mask_a: assert property (
		o_cmd_valid && o_cmd_op == scf_pkg::OP_SECTOR_ER |-> o_cmd_addr[11:0] == 12'h000)
		else $error("sector address not masked");
	sleep_cause_a: assert property (
		$rose(o_deep_sleep) |-> ##[0:6] o_cmd_op == scf_pkg::OP_DEEP_SLEEP) else $error("stray sleep");
endmodule : scf_chk

bind scf_cmd_decoder scf_chk i_chk (.i_clk, .i_rst_n, .i_cs_n, .i_busy, .o_sio_oe_n, .o_quad_mode,
	.o_cmd_valid, .o_cmd_op, .o_cmd_addr, .o_suspend, .o_resume, .o_abort, .o_deep_sleep,
	.o_status, .o_cfg, .o_burst_len);

// ===== dv/scf_host.sv
// Purpose: host controller model on the serial link
// Assumes: link clock idles low and runs only inside frames, 48 ns period
// Notes: data changes after a falling edge and is sampled just before a rising edge
module scf_host (
	output logic o_sck,
	output logic o_cs_n,
	output logic [3:0] o_sio,
	input wire logic [3:0] i_sio
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_sio = 4'h5;
	end
	task automatic send(input logic [7:0] b, input int w);
		for (int i = 8 - w; i >= 0; i -= w) begin
			o_sio = 4'((b >> i) & ((1 << w) - 1));
			#24 o_sck = 1'b1;
			#24 o_sck = 1'b0;
		end
	endtask : send
	task automatic recv(output logic [7:0] b, input int w);
		b = 8'h00;
		for (int i = 0; i < 8; i += w) begin
			o_sio = ~o_sio;
			#23 b = 8'((b << w) | (w == 1 ? {3'h0, i_sio[1]} : i_sio & 4'((1 << w) - 1)));
			#1 o_sck = 1'b1;
			#24 o_sck = 1'b0;
		end
	endtask : recv
	// opens a frame: opcode, then address bytes most significant first
	task automatic cmd(input logic [7:0] op, input int w, input int na, input logic [23:0] a);
		#7 o_cs_n = 1'b0;
		#17;
		send(op, w);
		for (int k = na - 1; k >= 0; k--) send(a[8*k +: 8], w);
	endtask : cmd
	task automatic stop;
		#10 o_cs_n = 1'b1;
		o_sio = ~o_sio;
		#300;
	endtask : stop
endmodule : scf_host

// ===== dv/test_serial_flash_command_decoder.sv
// Purpose: self-checking bench for the serial flash command decoder
// Assumes: host model drives the link, core inputs change on falling i_clk
// Notes: core events are noted in queues and checked by a monitor
module test_serial_flash_command_decoder;
	timeunit 1ns;
	timeprecision 100ps;
	`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
$display("[FAIL] t=%0t got %h exp %h", $time, g, e); end end
	localparam int AW = scf_pkg::ADDR_BITS;
	logic i_clk, i_rst_n, i_busy, i_reg_wr, sck, cs_n, o_rd_sid, o_quad_mode, o_cmd_valid;
	logic o_wr_valid, o_suspend, o_resume, o_abort, o_deep_sleep;
	logic [1:0] i_burst, o_burst_len;
	logic [3:0] h_sio, w_sio, o_sio, o_sio_oe_n;
	logic [7:0] i_status, i_cfg, i_dev_id, o_cmd_op, o_wr_byte, o_status, o_cfg, rd_data, e_wr;
	logic [23:0] o_rd_addr, o_cmd_addr;
	logic [31:0] e_ev;
	logic [47:0] pmap;
	logic [31:0] q_ev[$];
	logic [7:0] q_wr[$];
	int tests_run, fail_count, abort_n;
	function automatic logic [7:0] mem(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction : mem
	assign rd_data = mem(o_rd_addr);
	assign w_sio = (o_sio & ~o_sio_oe_n) | (h_sio & o_sio_oe_n);
	scf_cmd_decoder #(.ADDR_W(AW), .PMAP_N(6)) i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_sck(sck), .i_cs_n(cs_n), .i_sio(w_sio), .o_sio(o_sio), .o_sio_oe_n(o_sio_oe_n),
		.o_rd_addr(o_rd_addr), .o_rd_sid(o_rd_sid), .i_rd_data(rd_data), .i_prot_map(pmap),
		.i_dev_id(i_dev_id), .o_quad_mode(o_quad_mode), .o_cmd_valid(o_cmd_valid),
		.o_cmd_op(o_cmd_op), .o_cmd_addr(o_cmd_addr), .o_wr_valid(o_wr_valid),
		.o_wr_byte(o_wr_byte), .o_suspend(o_suspend), .o_resume(o_resume), .o_abort(o_abort),
		.o_deep_sleep(o_deep_sleep), .i_busy(i_busy), .i_reg_wr(i_reg_wr), .i_status(i_status),
		.i_cfg(i_cfg), .i_burst(i_burst), .o_status(o_status), .o_cfg(o_cfg),
		.o_burst_len(o_burst_len));
	scf_host u_host (.o_sck(sck), .o_cs_n(cs_n), .o_sio(h_sio), .i_sio(w_sio));
	initial begin
		i_clk = 1'b0;
		forever #12.5 i_clk = ~i_clk;
	end
	// ======
	// monitor: oldest note against each event
	always @(negedge i_clk) begin
		if (o_cmd_valid === 1'b1) begin
			e_ev = q_ev.size() ? q_ev.pop_front() : 32'hx;
			`CHK({o_cmd_op, o_cmd_addr}, e_ev)
		end
		if (o_wr_valid === 1'b1) begin
			e_wr = q_wr.size() ? q_wr.pop_front() : 8'hx;
			`CHK(o_wr_byte, e_wr)
		end
		if (o_abort === 1'b1) abort_n++;
	end
	task automatic tally_and_finish;
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic nf(input logic [7:0] op, input int w);
		q_ev.push_back({op, 24'h0});
		u_host.cmd(op, w, 0, 24'h0);
		u_host.stop();
	endtask : nf
	task automatic er(input logic [7:0] op, input logic [23:0] a, input logic [23:0] m);
		q_ev.push_back({op, a & m});
		u_host.cmd(op, 1, 3, a);
		u_host.stop();
	endtask : er
	task automatic load(input logic [7:0] s, input logic [7:0] c);
		@(negedge i_clk);
		i_status = s;
		i_cfg = c;
		i_burst = 2'h3;
		i_reg_wr = 1'b1;
		@(negedge i_clk);
		i_reg_wr = 1'b0;
	endtask : load
	initial begin
		#300us;
		fail_count++;
		tally_and_finish();
	end
	initial begin
		logic [7:0] b;
		logic [7:0] st;
		logic [7:0] cf;
		logic [23:0] top;
		logic [23:0] a;
		i_rst_n = 1'b0;
		i_busy = 1'b0;
		i_reg_wr = 1'b0;
		i_status = 8'h00;
		i_cfg = 8'h00;
		i_burst = 2'h0;
		void'($urandom(67991));
		pmap = 48'({$urandom, $urandom});
		i_dev_id = 8'($urandom);
		st = 8'($urandom);
		cf = 8'($urandom) | 8'h02;
		top = 24'((1 << AW) - 1);
		repeat (10) @(posedge i_clk);
		@(negedge i_clk);
		i_rst_n = 1'b1;
		@(negedge i_clk);
		`CHK(o_quad_mode, 1'b0)
		load(st, cf);
		// single-bit read across the top of the array
		a = (24'($urandom) & ~top) | (top - 24'h1);
		q_ev.push_back({scf_pkg::OP_READ, top - 24'h1});
		u_host.cmd(scf_pkg::OP_READ, 1, 3, a);
		for (int k = 0; k < 4; k++) begin
			u_host.recv(b, 1);
			`CHK(b, mem(24'((top - 24'h1 + 24'(k)) & top)))
		end
		u_host.stop();
		`CHK(o_sio_oe_n, 4'hf)
		er(scf_pkg::OP_SECTOR_ER, 24'($urandom) & top, 24'hfff000);
		er(scf_pkg::OP_BLOCK_ER, 24'h100000 | 24'($urandom % 65536), 24'hff0000);
		er(scf_pkg::OP_BLOCK_ER, 24'($urandom % 32768), 24'hffe000);
		nf(scf_pkg::OP_SUSPEND, 1);
		nf(scf_pkg::OP_RESUME, 1);
		nf(scf_pkg::OP_DEEP_SLEEP, 1);
		`CHK(o_deep_sleep, 1'b1)
		q_ev.push_back({scf_pkg::OP_WAKE_ID, 24'h0});
		u_host.cmd(scf_pkg::OP_WAKE_ID, 1, 3, 24'h0);
		u_host.recv(b, 1);
		`CHK(b, i_dev_id)
		u_host.stop();
		`CHK(o_deep_sleep, 1'b0)
		q_ev.push_back({scf_pkg::OP_RD_SID, 8'h0, a[15:0]});
		u_host.cmd(scf_pkg::OP_RD_SID, 1, 2, a);
		u_host.send(8'h00, 1);
		u_host.recv(b, 1);
		`CHK(b, mem({8'h0, a[15:0]}))
		`CHK(o_rd_sid, 1'b1)
		u_host.stop();
		q_ev.push_back({scf_pkg::OP_DUAL_OUT_RD, a & top});
		u_host.cmd(scf_pkg::OP_DUAL_OUT_RD, 1, 3, a);
		u_host.send(8'h00, 1);
		u_host.recv(b, 2);
		`CHK(b, mem(a & top))
		u_host.stop();
		u_host.cmd(8'h7e, 1, 0, 24'h0);
		u_host.send(8'hff, 1);
		`CHK(o_sio_oe_n, 4'hf)
		u_host.stop();
		// quad protocol
		nf(scf_pkg::OP_QUAD_ENTER, 1);
		`CHK(o_quad_mode, 1'b1)
		u_host.cmd(scf_pkg::OP_READ, 4, 3, a);
		u_host.send(8'h00, 4);
		`CHK(o_sio_oe_n, 4'hf)
		u_host.stop();
		q_wr.push_back(st);
		q_wr.push_back(cf);
		q_ev.push_back({scf_pkg::OP_WR_PMAP, 24'h0});
		u_host.cmd(scf_pkg::OP_WR_PMAP, 4, 0, 24'h0);
		u_host.send(st, 4);
		u_host.send(cf, 4);
		u_host.stop();
		q_ev.push_back({scf_pkg::OP_RD_PMAP, 24'h0});
		u_host.cmd(scf_pkg::OP_RD_PMAP, 4, 0, 24'h0);
		u_host.send(8'h00, 4);
		for (int k = 0; k < 2; k++) begin
			u_host.recv(b, 4);
			`CHK(b, pmap[8*k +: 8])
		end
		u_host.stop();
		nf(scf_pkg::OP_QUAD_EXIT, 4);
		`CHK(o_quad_mode, 1'b0)
		nf(scf_pkg::OP_QUAD_EXIT, 1);
		`CHK(o_quad_mode, 1'b0)
		nf(scf_pkg::OP_QUAD_ENTER, 1);
		// soft reset in quad while a write is busy, two frames
		nf(scf_pkg::OP_RST_ARM, 4);
		@(negedge i_clk);
		i_busy = 1'b1;
		nf(scf_pkg::OP_RST_FIRE, 4);
		@(negedge i_clk);
		i_busy = 1'b0;
		`CHK(o_quad_mode, 1'b0)
		`CHK(o_status, st & 8'h30)
		`CHK(o_burst_len, 2'h0)
		`CHK(o_cfg, cf & 8'hfd)
		`CHK(abort_n, 1)
		u_host.cmd(scf_pkg::OP_QUAD_OUT_RD, 1, 3, a);
		u_host.send(8'h00, 4);
		`CHK(o_sio_oe_n, 4'hf)
		u_host.stop();
		// an idle opcode between arm and fire disarms
		load(st, cf);
		nf(scf_pkg::OP_RST_ARM, 1);
		nf(scf_pkg::OP_IDLE, 1);
		u_host.cmd(scf_pkg::OP_RST_FIRE, 1, 0, 24'h0);
		u_host.stop();
		`CHK(o_cfg, cf)
		`CHK(o_burst_len, 2'h3)
		q_ev.push_back({scf_pkg::OP_QUAD_OUT_RD, a & top});
		u_host.cmd(scf_pkg::OP_QUAD_OUT_RD, 1, 3, a);
		u_host.send(8'h00, 1);
		u_host.recv(b, 4);
		`CHK(b, mem(a & top))
		u_host.stop();
		`CHK(q_ev.size() + q_wr.size(), 0)
		tally_and_finish();
	end
endmodule : test_serial_flash_command_decoder
